// ---- rtl/sdo_sync_detect.sv ----
`timescale 1ns/1ps
// Operation
// - Green activity needs 64 matching pulses
// - Idle green noise never sets activity
// - Trilevel bit set without run check
// - Composite present on vertical inside source
// - Pass-through syncs are unclocked input copies, except vertical when green is selected
// - Green selected: separated vertical on vertical
// - Pass-through and separator run in power-down
// - Line sync trailing edge at pixel 0
// - Line sync width and polarity programmable
// - Width rounds even wide, odd YUV
// - Frame sync changes at pixel 7
// - All six inputs monitored, activity, polarity
module sdo_sync_detect
  import sdo_pkg::*;
#(
  parameter int ACT_TIMEOUT = sdo_pkg::ACT_TIMEOUT_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire sdo_pkg::sdo_sync_in_type sync_in,
  input wire logic power_down,
  input wire logic line_start,
  input wire sdo_pkg::sdo_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic hsync_passthru,
  output logic vsync_passthru,
  output logic aligned_line_sync,
  output logic aligned_frame_sync
);
  import sdo_pkg::*;

  localparam logic [20:0] TMR_MAX = 21'h1F_FFFF;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [11:0] PIX_MAX = 12'hFFF;

  typedef struct packed {
    logic [5:0] lvl;
    logic [5:0][20:0] act_tmr;
    logic [5:0] act;
    logic [5:0][15:0] pol_acc;
    logic [5:0] pol;
    logic [1:0][15:0] g_cnt;
    logic [1:0][15:0] g_hi;
    logic [1:0][15:0] g_per_prev;
    logic [1:0][15:0] g_wid_prev;
    logic [1:0][6:0] g_run;
    logic [1:0] g_act;
    logic [15:0] tri_win;
    logic [20:0] tri_tmr;
    logic [15:0] sep_run;
    logic [15:0] sep_gap;
    logic vsep;
    logic [20:0] comp_tmr;
    logic [11:0] pix;
    logic [11:0] line_len;
    logic line_q;
    logic frame_q;
    logic [7:0] input_cfg;
    logic [7:0] output_cfg;
    logic [7:0] line_width;
    logic [7:0] rdata;
  } sdo_state_type;

  sdo_state_type q, d;

  // Pulse period or width match within tolerance
  function automatic logic sdo_near(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] diff;
    diff = (a > b) ? a - b : b - a;
    return diff <= 16'(PULSE_TOL);
  endfunction : sdo_near

  // Saturating event timer
  function automatic logic [20:0] sdo_tick(input logic [20:0] t);
    return (t == TMR_MAX) ? t : t + 21'h0_0001;
  endfunction : sdo_tick

  // Flattened input vector: hs0, vs0, g0, hs1, vs1, g1
  logic [5:0] sin_v;
  logic chan;
  logic [1:0] src;
  logic comp_raw;
  logic [7:0] width_eff;
  assign sin_v = {sync_in.green[1], sync_in.vsync[1], sync_in.hsync[1],
                  sync_in.green[0], sync_in.vsync[0], sync_in.hsync[0]};
  assign chan = q.input_cfg[IN_CHAN_BIT];
  assign src = q.input_cfg[IN_SRC_LO +: 2];
  assign comp_raw = (src == SRC_GREEN) ? sync_in.green[chan] : sync_in.hsync[chan];

  // Effective line sync width in pixel clocks
  always_comb begin
    if (q.output_cfg[OUT_WIDE_BIT]) begin
      width_eff = {q.line_width[7:1], 1'b0};
    end else if (q.input_cfg[IN_YUV_BIT]) begin
      width_eff = {q.line_width[7:1], 1'b1};
    end else begin
      width_eff = q.line_width;
    end
  end

  // Pass-through syncs, combinational copies of the selected channel, except vertical from the separator when green is selected
  assign hsync_passthru = (src == SRC_GREEN) ? sync_in.green[chan] : sync_in.hsync[chan];
  assign vsync_passthru = (src == SRC_GREEN) ? q.vsep : sync_in.vsync[chan];

  // Next state
  always_comb begin
    logic rise;
    logic fall;
    logic comp_act;
    logic vert_act;
    logic line_act;
    logic [11:0] next_pix;
    logic [15:0] per;
    logic [15:0] wid;
    rise = 1'b0;
    fall = 1'b0;
    comp_act = 1'b0;
    vert_act = 1'b0;
    line_act = 1'b0;
    next_pix = '0;
    per = '0;
    wid = '0;
    d = q;
    d.lvl = sin_v;

    // Activity and polarity on all six inputs
    for (int i = 0; i < 6; i++) begin
      rise = sin_v[i] & ~q.lvl[i];
      d.act_tmr[i] = (sin_v[i] != q.lvl[i]) ? '0 : sdo_tick(q.act_tmr[i]);
      d.act[i] = q.act_tmr[i] < 21'(ACT_TIMEOUT);
      if (rise) begin
        d.pol[i] = q.pol_acc[i][15]; // Mostly low means active high
        d.pol_acc[i] = '0;
      end else if (sin_v[i] && q.pol_acc[i] != 16'h7FFF) begin
        d.pol_acc[i] = q.pol_acc[i] + 16'h0001;
      end else if (!sin_v[i] && q.pol_acc[i] != 16'h8000) begin
        d.pol_acc[i] = q.pol_acc[i] - 16'h0001;
      end
    end

    // Green channel run of matching pulses per channel
    for (int c = 0; c < 2; c++) begin
      rise = sin_v[3 * c + 2] & ~q.lvl[3 * c + 2];
      per = q.g_cnt[c];
      wid = q.g_hi[c];
      if (rise) begin
        d.g_cnt[c] = 16'h0001;
        d.g_hi[c] = 16'h0001;
        d.g_per_prev[c] = per;
        d.g_wid_prev[c] = wid;
        if (wid < 16'(MIN_PULSE_CYC)) begin
          d.g_run[c] = '0; // Glitch breaks the run
          d.g_act[c] = 1'b0;
        end else if (sdo_near(per, q.g_per_prev[c]) && sdo_near(wid, q.g_wid_prev[c])) begin
          if (q.g_run[c] != 7'(GREEN_RUN)) begin
            d.g_run[c] = q.g_run[c] + 7'h01;
          end
          d.g_act[c] = (q.g_run[c] + 7'h01) >= 7'(GREEN_RUN);
        end else begin
          d.g_run[c] = '0;
          d.g_act[c] = 1'b0;
        end
      end else if (q.g_cnt[c] == CNT_MAX) begin
        d.g_run[c] = '0; // Flat clamped level
        d.g_act[c] = 1'b0;
      end else begin
        d.g_cnt[c] = q.g_cnt[c] + 16'h0001;
        d.g_hi[c] = q.g_hi[c] + 16'(sin_v[3 * c + 2]);
      end
    end

    // Trilevel: upper excursion just after a green sync tip, no run check
    fall = ~sync_in.green[chan] & q.lvl[3 * chan + 2];
    if (fall) begin
      d.tri_win = 16'(TRI_WIN_CYC);
    end else if (q.tri_win != '0) begin
      d.tri_win = q.tri_win - 16'h0001;
    end
    d.tri_tmr = (sync_in.trilevel[chan] && q.tri_win != '0) ? '0 : sdo_tick(q.tri_tmr);

    // Sync separator on the selected composite source, kept running in power-down
    comp_act = comp_raw == q.pol[3 * chan + ((src == SRC_GREEN) ? 2 : 0)];
    if (comp_act) begin
      d.sep_gap = '0;
      d.sep_run = (q.sep_run == CNT_MAX) ? q.sep_run : q.sep_run + 16'h0001;
      if (q.sep_run >= 16'(BROAD_CYC)) begin
        d.vsep = 1'b1; // Broad pulse opens the vertical interval
      end
    end else begin
      d.sep_run = '0;
      d.sep_gap = (q.sep_gap == CNT_MAX) ? q.sep_gap : q.sep_gap + 16'h0001;
      if (q.sep_gap >= 16'(GAP_CYC)) begin
        d.vsep = 1'b0; // Equalization spacing holds it, a full line gap ends it
      end
    end
    d.comp_tmr = (d.vsep && !q.vsep) ? '0 : sdo_tick(q.comp_tmr);

    // Pixel position of the next cycle, pixel 0 being the line_start cycle itself
    next_pix = line_start ? 12'h001 : ((q.pix == PIX_MAX) ? q.pix : q.pix + 12'h001);
    d.pix = next_pix;
    if (line_start) begin
      d.line_len = q.pix; // Pixels since the previous line start
    end
    // Active on the last pixels of a line so that it ends as pixel 0 appears
    line_act = !power_down && next_pix < q.line_len &&
               ({1'b0, next_pix} + {5'h00, width_eff} >= {1'b0, q.line_len});
    d.line_q = line_act ? q.output_cfg[OUT_LINE_POL_BIT] : ~q.output_cfg[OUT_LINE_POL_BIT];
    vert_act = (src == SRC_SEPARATE) ? (sync_in.vsync[chan] == q.pol[3 * chan + 1]) : q.vsep;
    if (next_pix == 12'(FRAME_PIXEL) || power_down) begin
      d.frame_q = (vert_act && !power_down) ? q.output_cfg[OUT_FRAME_POL_BIT]
                                            : ~q.output_cfg[OUT_FRAME_POL_BIT];
    end

    // Register writes
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        ADDR_INPUT_CFG: d.input_cfg = reg_req.wdata;
        ADDR_OUTPUT_CFG: d.output_cfg = reg_req.wdata;
        ADDR_LINE_WIDTH: d.line_width = reg_req.wdata;
        default: d.input_cfg = q.input_cfg;
      endcase
    end

    // Register reads, answered the next cycle
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        ADDR_STATUS: begin
          d.rdata = {(src != SRC_SEPARATE) && q.comp_tmr < 21'(ACT_TIMEOUT),
                     q.tri_tmr < 21'(ACT_TIMEOUT),
                     q.g_act[1], q.act[4], q.act[3], q.g_act[0], q.act[1], q.act[0]};
        end
        ADDR_POLARITY: d.rdata = {2'b00, q.pol};
        ADDR_INPUT_CFG: d.rdata = q.input_cfg;
        ADDR_OUTPUT_CFG: d.rdata = q.output_cfg;
        ADDR_LINE_WIDTH: d.rdata = q.line_width;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.act_tmr <= {6{TMR_MAX}};
      q.tri_tmr <= TMR_MAX;
      q.comp_tmr <= TMR_MAX;
      q.pix <= PIX_MAX; // No frame edge before the first line start
      q.line_q <= ~OUTPUT_CFG_RST[OUT_LINE_POL_BIT];
      q.frame_q <= ~OUTPUT_CFG_RST[OUT_FRAME_POL_BIT];
      q.input_cfg <= INPUT_CFG_RST;
      q.output_cfg <= OUTPUT_CFG_RST;
      q.line_width <= LINE_WIDTH_RST;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign aligned_line_sync = q.line_q;
  assign aligned_frame_sync = q.frame_q;
endmodule : sdo_sync_detect

// ---- rtl/unused_placeholder_none.sv ----
`timescale 1ns/1ps

// ---- shared/sdo_pkg.sv ----
package sdo_pkg;
  // Clock
  localparam int CLK_MHZ = 50;

  // Register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_POLARITY = 8'h02;
  localparam logic [7:0] ADDR_INPUT_CFG = 8'h05;
  localparam logic [7:0] ADDR_OUTPUT_CFG = 8'h18;
  localparam logic [7:0] ADDR_LINE_WIDTH = 8'h19;

  // Reset values
  localparam logic [7:0] INPUT_CFG_RST = 8'h00;
  localparam logic [7:0] OUTPUT_CFG_RST = 8'hC0;
  localparam logic [7:0] LINE_WIDTH_RST = 8'h10;

  // Field positions
  localparam int IN_CHAN_BIT = 0;
  localparam int IN_YUV_BIT = 2;
  localparam int IN_SRC_LO = 3;
  localparam int OUT_WIDE_BIT = 0;
  localparam int OUT_FRAME_POL_BIT = 6;
  localparam int OUT_LINE_POL_BIT = 7;
  localparam int STAT_TRILEVEL_BIT = 6;
  localparam int STAT_COMPOSITE_BIT = 7;

  // Sync source selection in input config bits 4:3
  localparam logic [1:0] SRC_SEPARATE = 2'h0;
  localparam logic [1:0] SRC_COMPOSITE_HSYNC = 2'h1;
  localparam logic [1:0] SRC_GREEN = 2'h2;

  // Detection figures
  localparam int GREEN_RUN = 64;
  localparam int PULSE_TOL = 2;
  localparam int ACT_TIMEOUT_NS = 40_000_000;
  localparam int MIN_PULSE_NS = 100;
  localparam int BROAD_NS = 10_000;
  localparam int GAP_NS = 40_000;
  localparam int TRI_WIN_NS = 2_000;
  localparam int FRAME_PIXEL = 7;

  // Cycle counts, least times round up
  localparam int ACT_TIMEOUT_CYC = (ACT_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int BROAD_CYC = (BROAD_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int TRI_WIN_CYC = (TRI_WIN_NS * CLK_MHZ) / 1000;

  // Raw sync inputs, index 0 and 1 are the two channels
  typedef struct packed {
    logic [1:0] hsync;
    logic [1:0] vsync;
    logic [1:0] green;
    logic [1:0] trilevel;
  } sdo_sync_in_type;

  // Register access port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sdo_reg_req_type;
endpackage : sdo_pkg

// ---- tb/sdo_pixel_src.sv ----
`timescale 1ns/1ps
module sdo_pixel_src #(
  parameter int LINE_LEN = 40
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic line_start
);
  int pix_q;
  // Marks pixel 0 once a line, off the falling edge
  always @(negedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pix_q <= 0;
      line_start <= 1'b0;
    end else begin
      pix_q <= (pix_q == LINE_LEN - 1) ? 0 : pix_q + 1;
      line_start <= pix_q == LINE_LEN - 1;
    end
  end
endmodule : sdo_pixel_src

// ---- tb/sdo_sync_detect_properties.sv ----
`timescale 1ns/1ps
module sdo_chk
  import sdo_pkg::*;
#(
  parameter int ACT_TIMEOUT = 200
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire sdo_pkg::sdo_sync_in_type sync_in,
  input wire logic power_down,
  input wire logic line_start,
  input wire sdo_pkg::sdo_reg_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic hsync_passthru,
  input wire logic vsync_passthru,
  input wire logic aligned_line_sync,
  input wire logic aligned_frame_sync
);
  logic [7:0] in_q, out_q, wid_q, run_q, rise_q, exp_w;
  logic gp_q;
  logic grn;
  // Source select and rounded line width
  assign grn = in_q[4:3] == SRC_GREEN;
  assign exp_w = out_q[0] ? (wid_q & 8'hFE) : (in_q[2] ? (wid_q | 8'h01) : wid_q);
  // Config shadow, active run length, green rises
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_q <= INPUT_CFG_RST;
      out_q <= OUTPUT_CFG_RST;
      wid_q <= LINE_WIDTH_RST;
      run_q <= 8'h00;
      rise_q <= 8'h00;
      gp_q <= 1'b0;
    end else begin
      if (reg_req.wr && reg_req.addr == ADDR_INPUT_CFG) in_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == ADDR_OUTPUT_CFG) out_q <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == ADDR_LINE_WIDTH) wid_q <= reg_req.wdata;
      run_q <= (aligned_line_sync == out_q[7]) ? run_q + 8'h01 : 8'h00;
      rise_q <= (sync_in.green[0] && !gp_q && rise_q != 8'hFF) ? rise_q + 8'h01 : rise_q;
      gp_q <= sync_in.green[0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_hsync_copy: assert property (!grn |-> hsync_passthru == sync_in.hsync[in_q[0]])
    else $error("hsync copy wrong");
  a_green_copy: assert property (grn |-> hsync_passthru == sync_in.green[in_q[0]])
    else $error("green copy wrong");
  a_vsync_copy: assert property (!grn |-> vsync_passthru == sync_in.vsync[in_q[0]])
    else $error("vsync copy wrong");
  a_idle_down: assert property (power_down
    |=> aligned_line_sync == !out_q[7] && aligned_frame_sync == !out_q[6])
    else $error("outputs active in power down");
  a_line_pix0: assert property (line_start |-> aligned_line_sync == !out_q[7])
    else $error("line sync active on pixel 0");
  a_line_width: assert property (line_start && run_q != 8'h00 |-> run_q == exp_w)
    else $error("line sync width wrong");
  a_frame_pix7: assert property ($changed(aligned_frame_sync) && !$past(power_down) && !$past(power_down, 2)
    && !$past(reg_req.wr) && !$past(reg_req.wr, 2) |-> $past(line_start, 7))
    else $error("frame sync moved off pixel 7");
  a_green_run: assert property (reg_req.rd && reg_req.addr == ADDR_STATUS
    |=> !reg_rdata[2] || $past(rise_q) >= 8'h40)
    else $error("green activity before 64 pulses");
endmodule : sdo_chk
bind sdo_sync_detect sdo_chk #(.ACT_TIMEOUT(ACT_TIMEOUT)) chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .sync_in(sync_in), .power_down(power_down), .line_start(line_start), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .hsync_passthru(hsync_passthru), .vsync_passthru(vsync_passthru),
  .aligned_line_sync(aligned_line_sync), .aligned_frame_sync(aligned_frame_sync));

// ---- tb/sync_detect_and_sync_outputs_bench.sv ----
`timescale 1ns/1ps
module sync_detect_and_sync_outputs_bench;
  import sdo_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_down = 1'b0;
  logic line_start;
  sdo_sync_in_type sync_in = '0;
  sdo_reg_req_type reg_req = '0;
  logic [7:0] reg_rdata;
  logic hs_p, vs_p, ls_o, fs_o;
  int mismatches = 0;
  int total_checks = 0;
  sdo_sync_detect #(.ACT_TIMEOUT(200)) uut (.sys_clk(sys_clk), .reset_n(reset_n), .sync_in(sync_in),
    .power_down(power_down), .line_start(line_start), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .hsync_passthru(hs_p), .vsync_passthru(vs_p), .aligned_line_sync(ls_o), .aligned_frame_sync(fs_o));
  sdo_pixel_src src (.sys_clk(sys_clk), .reset_n(reset_n), .line_start(line_start));
  initial forever #10 sys_clk = ~sys_clk;
  task test_done;
    if (mismatches == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task check(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task wr(input logic [7:0] a, d);
    @(negedge sys_clk);
    reg_req = '{1'b1, 1'b0, a, d};
    @(negedge sys_clk);
    reg_req = '0;
  endtask : wr
  task rc(input string nm, input logic [7:0] a, m, e);
    @(negedge sys_clk);
    reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge sys_clk);
    reg_req = '0;
    @(negedge sys_clk);
    check(nm, e, reg_rdata & m);
  endtask : rc
  // Returns inside the pixel 0 cycle
  task wait_line;
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      #1;
      n++;
    end while (line_start !== 1'b1 && n < 100);
    if (n >= 100) begin
      mismatches++;
      test_done();
    end
  endtask : wait_line
  task pulses(input int n, per);
    repeat (n) begin
      sync_in.green[0] = 1'b1;
      repeat (8) @(negedge sys_clk);
      sync_in.green[0] = 1'b0;
      repeat (per - 8) @(negedge sys_clk);
    end
  endtask : pulses
  task t_pass;
    logic [1:0] p;
    for (int c = 0; c < 2; c++) begin
      for (int i = 0; i < 8; i++) begin
        wait_line();
        wr(ADDR_INPUT_CFG, i[2] ? (8'h10 | 8'(c)) : 8'(c));
        p = c[0] ? {i[0], !i[0]} : {!i[0], i[0]};
        power_down = i[1];
        sync_in.hsync = p;
        sync_in.green = ~p;
        sync_in.vsync = i[1] ? p : ~p;
        #1;
        check("hsync_out", 8'(i[2] ? sync_in.green[c] : sync_in.hsync[c]), 8'(hs_p));
        if (!i[2]) check("vsync_out", 8'(sync_in.vsync[c]), 8'(vs_p));
      end
    end
    power_down = 1'b0;
  endtask : t_pass
  task t_green;
    wait_line();
    wr(ADDR_INPUT_CFG, 8'h10);
    sync_in = '0;
    repeat (250) @(negedge sys_clk);
    rc("hsync_idle", ADDR_STATUS, 8'h09, 8'h00);
    sync_in.trilevel[0] = 1'b1;
    pulses(2, 40);
    rc("trilevel", ADDR_STATUS, 8'h40, 8'h40);
    sync_in.trilevel[0] = 1'b0;
    fork
      pulses(80, 40); // Clean pulses with no protection pulses
      begin
        repeat (2500) @(negedge sys_clk);
        rc("green_short", ADDR_STATUS, 8'h04, 8'h00);
        repeat (660) @(negedge sys_clk);
        rc("green_run", ADDR_STATUS, 8'h04, 8'h04);
      end
    join
    repeat (30) @(negedge sys_clk);
    pulses(1, 40);
    rc("green_lost", ADDR_STATUS, 8'h04, 8'h00);
    sync_in.green[0] = 1'b1;
    repeat (600) @(negedge sys_clk);
    check("vsync_sep", 8'h01, 8'(vs_p));
    sync_in.green[0] = 1'b0;
    repeat (5) @(negedge sys_clk);
    rc("composite", ADDR_STATUS, 8'h80, 8'h80);
  endtask : t_green
  task t_lines;
    logic [7:0] tb [4][4];
    int n;
    tb = '{'{8'h00, 8'hC0, 8'h05, 8'h05}, '{8'h00, 8'hC1, 8'h05, 8'h04},
      '{8'h04, 8'hC0, 8'h04, 8'h05}, '{8'h00, 8'h40, 8'h03, 8'h03}};
    for (int k = 0; k < 4; k++) begin
      wait_line();
      if (k == 0) check("frame_on", 8'h01, 8'(fs_o));
      wr(ADDR_INPUT_CFG, tb[k][0]);
      wr(ADDR_OUTPUT_CFG, tb[k][1]);
      wr(ADDR_LINE_WIDTH, tb[k][2]);
      rc("width_reg", ADDR_LINE_WIDTH, 8'hFF, tb[k][2]);
      wait_line();
      check("line_pix0", 8'(!tb[k][1][7]), 8'(ls_o));
      n = 0;
      repeat (40) begin
        @(negedge sys_clk);
        #1;
        if (ls_o === tb[k][1][7]) n++;
      end
      check("line_width", tb[k][3], 8'(n));
    end
  endtask : t_lines
  initial begin
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n <= 1'b1;
    rc("input_cfg", ADDR_INPUT_CFG, 8'hFF, INPUT_CFG_RST);
    rc("output_cfg", ADDR_OUTPUT_CFG, 8'hFF, 8'hC0);
    rc("line_width", ADDR_LINE_WIDTH, 8'hFF, LINE_WIDTH_RST);
    rc("status", ADDR_STATUS, 8'hFF, 8'h00);
    rc("unmapped", 8'h7E, 8'hFF, 8'h00);
    t_pass();
    t_green();
    t_lines();
    test_done();
  end
endmodule : sync_detect_and_sync_outputs_bench
